// ===== rtl/ssac_pkg.sv
// shared constants and types for the simultaneous-sample converter control
package ssac_pkg;
  // ---------------------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------------------
  localparam int          SSAC_NCH         = 4;
  localparam int          SSAC_DW          = 12;
  localparam logic [3:0]  SSAC_CHSEL_RST   = 4'hF;   // all channels after reset
  localparam logic [3:0]  SSAC_CONV_EXT_CYC = 4'hE;  // fourteen external clock cycles
  // internal conversion time in ns and its count at 50 MHz
  localparam int          SSAC_CLK_NS      = 20;
  localparam int          SSAC_TCONV_NS    = 1650;
  localparam int          SSAC_CONV_INT_CYC_I = SSAC_TCONV_NS / SSAC_CLK_NS;
  localparam logic [6:0]  SSAC_CONV_INT_CYC = 7'(SSAC_CONV_INT_CYC_I);
  // done pulse length: 75 ns least, rounded up to cycles
  localparam int          SSAC_DONE_NS     = 75;
  localparam logic [2:0]  SSAC_DONE_CYC    = 3'((SSAC_DONE_NS + SSAC_CLK_NS - 1) / SSAC_CLK_NS);
  localparam logic [1:0]  SSAC_PTR_FIRST   = 2'h0;

  // ---------------------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SSAC_IDLE = 2'b00,
    SSAC_CONV = 2'b01,
    SSAC_DONE = 2'b10
  } ssac_state_t;
endpackage

// ===== rtl/ssac_edge.sv
// one-cycle rise and fall detector for a synchronous input
`timescale 1ns/100ps
module ssac_edge (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // level in, edges out
  input  wire logic din,
  output logic      rise,
  output logic      fall
);
  logic last_r;
  logic last_nxt;

  // ---------------------------------------------------------------------------
  // history
  // ---------------------------------------------------------------------------
  // reset to high: idle level of the active-low strobes
  always_comb begin
    last_nxt = din;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      last_r <= 1'b1;
    end else begin
      last_r <= last_nxt;
    end
  end

  assign rise = din & ~last_r;
  assign fall = ~din & last_r;
endmodule // ssac_edge

// ===== rtl/ssac_ctrl.sv
// conversion control and parallel host interface of a four-channel converter
//
// Contract
// - busy rises on start edge, holds till done
// - first flag high when pointer at first result
// - start edge holds all four and converts
// - sequence selection latched at start edge
// - strobes only acted on while selected
// - data driven only while read and select low
// - write rise stores four low lines
// - source select picks pins or register
// - bit 0 is channel 1, bit 3 channel 4
// - clock select picks internal or external clock
// - external: fourteen cycles, one done pulse each
// - standby low enters power save
`timescale 1ns/100ps
module ssac_ctrl
  import ssac_pkg::*;
#(
  parameter int NCH = ssac_pkg::SSAC_NCH,
  parameter int DW  = ssac_pkg::SSAC_DW
) (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            srst,
  // conversion control
  input  wire logic            convert_start_n,
  input  wire logic [NCH-1:0]  hw_channel_select,
  input  wire logic            sequence_source_select,
  input  wire logic            clock_source_select,
  input  wire logic            external_conv_clock,
  input  wire logic            standby_n,
  // converter core: result of the channel being converted
  input  wire logic [DW-1:0]   conv_result,
  // host strobes
  input  wire logic            select_n,
  input  wire logic            read_strobe_n,
  input  wire logic            write_strobe_n,
  // data bus, in and out per pin, one shared enable
  input  wire logic [DW-1:0]   data_in,
  output logic      [DW-1:0]   data_out,
  output logic                 data_oe,
  // status
  output logic                 busy,
  output logic                 conversion_done_n,
  output logic                 first_result_flag,
  output logic      [NCH-1:0]  track_hold,
  output logic      [NCH-1:0]  chan_converting,
  output logic                 power_save
);
  import ssac_pkg::*;

  // ---------------------------------------------------------------------------
  // edge detection
  // ---------------------------------------------------------------------------
  logic cs_rise;
  logic rd_rise;
  logic wr_rise;
  logic xc_rise;

  // only rising edges matter here, falling outputs left open
  ssac_edge u_cs (.clk(clk), .srst(srst), .din(convert_start_n),
                  .rise(cs_rise), .fall());
  ssac_edge u_rd (.clk(clk), .srst(srst), .din(read_strobe_n),
                  .rise(rd_rise), .fall());
  ssac_edge u_wr (.clk(clk), .srst(srst), .din(write_strobe_n),
                  .rise(wr_rise), .fall());
  ssac_edge u_xc (.clk(clk), .srst(srst), .din(external_conv_clock),
                  .rise(xc_rise), .fall());

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  ssac_state_t            state_r, state_nxt;
  logic [NCH-1:0]         chsel_r, chsel_nxt;     // channel select register
  logic [NCH-1:0]         seq_r, seq_nxt;         // latched sequence, still to convert
  logic [NCH-1:0]         done_r, done_nxt;       // results written this sequence
  logic [1:0]             cur_r, cur_nxt;         // channel being converted
  logic [6:0]             cnt_r, cnt_nxt;
  logic [2:0]             pw_r, pw_nxt;
  logic [1:0]             ptr_r, ptr_nxt;         // output result pointer
  logic [DW-1:0]          res_r [NCH];
  logic [DW-1:0]          res_nxt [NCH];
  logic                   busy_r, busy_nxt;
  logic                   eoc_n_r, eoc_n_nxt;
  logic                   frst_r, frst_nxt;
  logic [NCH-1:0]         th_r, th_nxt;
  logic [NCH-1:0]         conv_r, conv_nxt;
  logic [DW-1:0]          dout_r, dout_nxt;
  logic                   doe_r, doe_nxt;
  logic                   ps_r, ps_nxt;

  logic                   sel_ok;
  logic [NCH-1:0]         seq_src;
  logic                   tick;
  logic [1:0]             nxt_ch;
  logic                   nxt_any;
  logic [1:0]             nxt_rd;

  // lowest set bit of a mask, ascending channel order
  function automatic logic [2:0] first_set(input logic [NCH-1:0] m);
    logic [2:0] r;
    r = 3'h4;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [2:0] f;
    logic [2:0] g;
    f         = 3'h0;
    g         = 3'h0;
    sel_ok    = ~select_n;
    seq_src   = sequence_source_select ? chsel_r : hw_channel_select;
    tick      = clock_source_select ? xc_rise : 1'b1;
    state_nxt = state_r;
    chsel_nxt = chsel_r;
    seq_nxt   = seq_r;
    done_nxt  = done_r;
    cur_nxt   = cur_r;
    cnt_nxt   = cnt_r;
    pw_nxt    = pw_r;
    ptr_nxt   = ptr_r;
    for (int i = 0; i < NCH; i++) begin
      res_nxt[i] = res_r[i];
    end
    busy_nxt  = busy_r;
    eoc_n_nxt = eoc_n_r;
    th_nxt    = th_r;
    conv_nxt  = '0;
    ps_nxt    = ~standby_n;

    // software channel select write, host keeps read high while writing
    if (sel_ok && wr_rise && read_strobe_n) begin
      chsel_nxt = data_in[NCH-1:0];
    end

    // remaining selected channel after the current one
    f       = first_set(seq_r & ~(NCH'(1) << cur_r));
    nxt_any = ~f[2];
    nxt_ch  = f[1:0];

    // pointer: next written result above current, else wrap to first
    g      = first_set(done_r & ~((NCH'(2) << ptr_r) - NCH'(1)));
    nxt_rd = g[2] ? SSAC_PTR_FIRST : g[1:0];
    if (sel_ok && rd_rise) begin
      ptr_nxt = nxt_rd;
    end

    // done pulse width
    if (!eoc_n_r) begin
      if (pw_r == 3'h1) begin
        eoc_n_nxt = 1'b1;
      end else begin
        pw_nxt = pw_r - 3'h1;
      end
    end

    unique case (state_r)
      SSAC_IDLE: begin
        // standby blocks new sequences: the core is powered down
        if (cs_rise && standby_n) begin
          f        = first_set(seq_src);
          seq_nxt  = seq_src;
          done_nxt = '0;
          ptr_nxt  = SSAC_PTR_FIRST;
          th_nxt   = '1;
          if (!f[2]) begin
            busy_nxt  = 1'b1;
            cur_nxt   = f[1:0];
            cnt_nxt   = clock_source_select ? 7'(SSAC_CONV_EXT_CYC) : SSAC_CONV_INT_CYC;
            state_nxt = SSAC_CONV;
          end else begin
            th_nxt = '0;
          end
        end
      end
      SSAC_CONV: begin
        conv_nxt[cur_r] = 1'b1;
        if (tick) begin
          if (cnt_r == 7'h1) begin
            // slots fill in conversion order: slot 0 always holds the first result
            g                = first_set(~done_r);
            res_nxt[g[1:0]]  = conv_result;
            done_nxt[g[1:0]] = 1'b1;
            eoc_n_nxt       = 1'b0;
            pw_nxt          = SSAC_DONE_CYC;
            state_nxt       = SSAC_DONE;
          end else begin
            cnt_nxt = cnt_r - 7'h1;
          end
        end
      end
      SSAC_DONE: begin
        // waits out the done pulse before the next channel
        if (eoc_n_r) begin
          if (nxt_any) begin
            seq_nxt   = seq_r & ~(NCH'(1) << cur_r);
            cur_nxt   = nxt_ch;
            cnt_nxt   = clock_source_select ? 7'(SSAC_CONV_EXT_CYC) : SSAC_CONV_INT_CYC;
            state_nxt = SSAC_CONV;
          end else begin
            busy_nxt  = 1'b0;
            th_nxt    = '0;
            state_nxt = SSAC_IDLE;
          end
        end
      end
      default: begin
        state_nxt = SSAC_IDLE;
      end
    endcase

    frst_nxt = (ptr_nxt == SSAC_PTR_FIRST);
    doe_nxt  = ~read_strobe_n & ~select_n;
    dout_nxt = res_nxt[ptr_nxt];
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= SSAC_IDLE;
      chsel_r <= SSAC_CHSEL_RST;
      seq_r   <= '0;
      done_r  <= '0;
      cur_r   <= 2'h0;
      cnt_r   <= 7'h0;
      pw_r    <= 3'h0;
      ptr_r   <= SSAC_PTR_FIRST;
      for (int i = 0; i < NCH; i++) begin
        res_r[i] <= '0;
      end
      busy_r  <= 1'b0;
      eoc_n_r <= 1'b1;
      frst_r  <= 1'b1;
      th_r    <= '0;
      conv_r  <= '0;
      dout_r  <= '0;
      doe_r   <= 1'b0;
      ps_r    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      chsel_r <= chsel_nxt;
      seq_r   <= seq_nxt;
      done_r  <= done_nxt;
      cur_r   <= cur_nxt;
      cnt_r   <= cnt_nxt;
      pw_r    <= pw_nxt;
      ptr_r   <= ptr_nxt;
      for (int i = 0; i < NCH; i++) begin
        res_r[i] <= res_nxt[i];
      end
      busy_r  <= busy_nxt;
      eoc_n_r <= eoc_n_nxt;
      frst_r  <= frst_nxt;
      th_r    <= th_nxt;
      conv_r  <= conv_nxt;
      dout_r  <= dout_nxt;
      doe_r   <= doe_nxt;
      ps_r    <= ps_nxt;
    end
  end

  // outputs straight from flops
  assign busy              = busy_r;
  assign conversion_done_n = eoc_n_r;
  assign first_result_flag = frst_r;
  assign track_hold        = th_r;
  assign chan_converting   = conv_r;
  assign data_out          = dout_r;
  assign data_oe           = doe_r;
  assign power_save        = ps_r;
endmodule // ssac_ctrl

// ===== tb/ssac_ctrl_sva.sv
// checker on the converter control ports
`timescale 1ns/100ps
module ssac_ctrl_sva #(
  parameter int NCH = 4,
  parameter int DW  = 12
) (
  // clock and reset
  input wire logic           clk,
  input wire logic           srst,
  // host side
  input wire logic           select_n,
  input wire logic           read_strobe_n,
  input wire logic           standby_n,
  // status
  input wire logic           data_oe,
  input wire logic           busy,
  input wire logic           conversion_done_n,
  input wire logic           first_result_flag,
  input wire logic [NCH-1:0] track_hold,
  input wire logic [NCH-1:0] chan_converting,
  input wire logic           power_save
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // done pulse: three more clocks low, then high
  sequence s_done_low;
    !conversion_done_n [*3] ##1 conversion_done_n;
  endsequence
  property p_done_len;
    $fell(conversion_done_n) |=> s_done_low;
  endproperty
  a_done_len: assert property (p_done_len) else $error("done pulse length");
  property p_done_busy;
    !conversion_done_n |-> busy;
  endproperty
  a_done_busy: assert property (p_done_busy) else $error("done outside busy");
  property p_busy_end;
    $fell(busy) |-> $past(conversion_done_n) && $past(!conversion_done_n, 2);
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy fell early");
  property p_hold_all;
    track_hold == {NCH{busy}};
  endproperty
  a_hold_all: assert property (p_hold_all) else $error("hold not together");
  // reset edge excluded: the strobes then are not answered
  property p_drive;
    !$past(srst) |-> data_oe == $past(!read_strobe_n && !select_n);
  endproperty
  a_drive: assert property (p_drive) else $error("bus drive wrong");
  property p_one_chan;
    $onehot0(chan_converting) && (busy || chan_converting == '0);
  endproperty
  a_one_chan: assert property (p_one_chan) else $error("channel not one-hot");
  property p_first_at_start;
    $rose(busy) |-> ##[0:1] first_result_flag;
  endproperty
  a_first_at_start: assert property (p_first_at_start) else $error("pointer kept");
  property p_save;
    !$past(srst) |-> power_save == $past(!standby_n);
  endproperty
  a_save: assert property (p_save) else $error("power save wrong");
  property p_awake;
    $rose(busy) |-> $past(standby_n) && $past(standby_n, 2);
  endproperty
  a_awake: assert property (p_awake) else $error("start in standby");
endmodule // ssac_ctrl_sva

bind ssac_ctrl ssac_ctrl_sva #(.NCH(NCH), .DW(DW)) i_ssac_ctrl_sva (.clk, .srst, .select_n,
  .read_strobe_n, .standby_n, .data_oe, .busy, .conversion_done_n, .first_result_flag,
  .track_hold, .chan_converting, .power_save);

// ===== tb/ssac_host_model.sv
// host model: start, chip select, read and write strobes, data bus
`timescale 1ns/100ps
module ssac_host_model
  import ssac_pkg::*;
(
  input  wire logic               clk,
  output logic                    convert_start_n,
  output logic                    select_n,
  output logic                    read_strobe_n,
  output logic                    write_strobe_n,
  output logic      [SSAC_DW-1:0] data_in,
  input  wire logic [SSAC_DW-1:0] data_out,
  input  wire logic               data_oe
);
  // idle: all strobes high
  initial begin
    {convert_start_n, select_n, read_strobe_n, write_strobe_n} = 4'hF;
    data_in = '0;
  end
  // start pulse, the rise starts a sequence
  task automatic start();
    @(posedge clk) convert_start_n <= 1'b0;
    repeat (2) @(posedge clk);
    convert_start_n <= 1'b1;
  endtask
  // read; write strobe never touched here, slow stretches the access
  task automatic rd(input int slow, output logic [SSAC_DW-1:0] d, output logic oe);
    @(posedge clk) select_n <= 1'b0;
    read_strobe_n <= 1'b0;
    repeat (2 + slow) @(posedge clk);
    #1 d = data_out;
    oe = data_oe;
    @(posedge clk) read_strobe_n <= 1'b1;
    @(posedge clk) select_n <= 1'b1;
  endtask
  // write, held two clocks past the rise; sel low gives a refused write
  task automatic wr(input logic sel, input logic [3:0] v);
    @(posedge clk) select_n <= !sel;
    data_in <= {8'h00, v};
    write_strobe_n <= 1'b0;
    @(posedge clk) write_strobe_n <= 1'b1;
    repeat (2) @(posedge clk);
    select_n <= 1'b1;
    data_in <= ~data_in; // released bus must not look stable
  endtask
endmodule // ssac_host_model

// ===== tb/tb_ssac_ctrl.sv
// self-checking bench for the converter control
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module tb_ssac_ctrl
  import ssac_pkg::*;
;
  logic        clk = 1'b0, srst = 1'b1, standby_n = 1'b1, external_conv_clock = 1'b0;
  logic        sequence_source_select = 1'b0, clock_source_select = 1'b0;
  logic [3:0]  hw_channel_select = 4'h0, reg_exp = SSAC_CHSEL_RST, track_hold, chan_converting;
  logic [11:0] conv_result = 12'h000, base = 12'h000, data_in, data_out;
  logic        convert_start_n, select_n, read_strobe_n, write_strobe_n, data_oe, busy;
  logic        conversion_done_n, first_result_flag, power_save, done_q = 1'b1;
  logic [15:0] rnd = 16'h51FA;
  int          err_total = 0, cmp_count = 0, cyc = 0, done_cnt = 0;
  logic [6:0]  corner [6] = '{7'h51, 7'h78, 7'h1F, 7'h46, 7'h50, 7'h2B};

  ssac_ctrl i_ssac_ctrl (.clk, .srst, .convert_start_n, .hw_channel_select,
    .sequence_source_select, .clock_source_select, .external_conv_clock, .standby_n,
    .conv_result, .select_n, .read_strobe_n, .write_strobe_n, .data_in, .data_out, .data_oe,
    .busy, .conversion_done_n, .first_result_flag, .track_hold, .chan_converting, .power_save);
  ssac_host_model i_ssac_host_model (.clk, .convert_start_n, .select_n, .read_strobe_n,
    .write_strobe_n, .data_in, .data_out, .data_oe);

  // ----------------------------------------------------------------
  // stimulus helpers
  // ----------------------------------------------------------------
  initial forever #10 clk = ~clk;
  // external clock, period eight system clocks
  always begin
    repeat (4) @(posedge clk);
    external_conv_clock <= ~external_conv_clock;
  end
  // core result tagged by channel, so each register is told apart
  always @(posedge clk) conv_result <= base ^ {8'h00, chan_converting};
  // cycle count, done pulse count and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    done_q <= conversion_done_n;
    if (done_q && !conversion_done_n) done_cnt <= done_cnt + 1;
    if (cyc == 30000) begin
      err_total++;
      complete_run();
    end
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // channel of the k-th result, ascending
  function automatic int nth(input logic [3:0] m, input int k);
    for (int i = 0; i < 4; i++) begin
      if (m[i] && k == 0) return i;
      if (m[i]) k--;
    end
    return 0;
  endfunction
  // c: source, clock, write selected, mask
  task automatic run_seq(input logic [6:0] c);
    logic [3:0]  me;
    logic [11:0] d;
    logic        o;
    int          n, t0, dc, per, lo, hi;
    rnd = lfsr(rnd);
    base = rnd[11:0];
    hw_channel_select <= c[3:0];
    clock_source_select <= c[5];
    sequence_source_select <= c[6];
    i_ssac_host_model.wr(c[4], c[3:0]);
    if (c[4]) reg_exp = c[3:0];
    me = c[6] ? reg_exp : c[3:0];
    n = $countones(me);
    // per channel: conversion, done pulse and one gap; external phase adds up to seven
    per = c[5] ? 14 * 8 : SSAC_CONV_INT_CYC_I + SSAC_DONE_CYC + 1;
    lo = n * per + (c[5] ? 0 : 2);
    hi = n * per + (c[5] ? 7 : 2);
    dc = done_cnt;
    i_ssac_host_model.start();
    t0 = cyc;
    repeat (3) @(posedge clk);
    `CHK("busy", me != 4'h0, busy)
    if (n > 0) begin
      // late changes and a second start must not touch this sequence
      hw_channel_select <= ~me;
      i_ssac_host_model.wr(1'b1, ~reg_exp);
      reg_exp = ~reg_exp;
      i_ssac_host_model.start();
    end
    while (busy !== 1'b0 && cyc - t0 < 1000) @(posedge clk);
    `CHK("duration", 1'b1, n == 0 || (cyc-t0 >= lo && cyc-t0 <= hi))
    `CHK("done pulses", n, done_cnt - dc)
    for (int k = 0; k <= n && n > 0; k++) begin
      repeat (2) @(posedge clk);
      #1 `CHK("first flag", k % n == 0, first_result_flag)
      i_ssac_host_model.rd(k % 2, d, o);
      `CHK("drive", 1'b1, o)
      `CHK("result", base ^ (12'h001 << nth(me, k % n)), d)
    end
    $display("test sequence mask %h done", me);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    foreach (corner[i]) run_seq(corner[i]);
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      run_seq(rnd[6:0]);
    end
    // a start while powered down is ignored
    standby_n <= 1'b0;
    i_ssac_host_model.start();
    repeat (4) @(posedge clk);
    `CHK("standby busy", 1'b0, busy)
    `CHK("power save", 1'b1, power_save)
    standby_n <= 1'b1;
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    reg_exp = SSAC_CHSEL_RST;
    `CHK("reset first flag", 1'b1, first_result_flag)
    run_seq(7'h45);
    $display("test standby and reset done");
    complete_run();
  end
endmodule // tb_ssac_ctrl
